// ==== hw/ssp_status_pin_select.sv ====
// Purpose: Control register and source multiplexer of the second status pin.
// Assumes: All condition inputs are synchronous to clk; APB master obeys the
//          protocol; test logic drives test_claim and test_level.
// Notes:   One extra cycle from a condition or test change to the pin, two from a divider edge.
//
// Function
// - A 4-bit selector in bits 7:4 of the control register picks the pin source and resets to 0x2.
// - Code 0x0 shows primary reference signal loss and code 0x1 secondary reference signal loss.
// - Code 0x2 shows PLL lock loss.
// - Code 0x3 shows the R divider output halved, meaningful only when R is not bypassed.
// - Code 0x4 shows the N divider output halved.
// - Code 0xB shows the M divider output halved, valid only when M is not bypassed.
// - Code 0x8 shows VCO calibration in progress.
// - Code 0xA shows the interrupt summary, 0xD EEPROM activity, 0xE automatic switch back.
// - Bit 3 resets to one and makes the pin active high when set, active low when clear.
// - A test claim of the pin overrides the selector and the polarity.
// - The interrupt summary is derived from the interrupt flag register bits.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.svh"

module ssp_status_pin_select
   import ssp_pkg::*;
#(
   parameter int N_DIV = 3
)
(
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // APB slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   input  wire logic [3:0]    pstrb,
   output logic               pready,
   output logic               pslverr,
   output logic [31:0]        prdata,
   // Conditions
   input  wire logic          pri_signal_loss_flag,
   input  wire logic          sec_signal_loss_flag,
   input  wire logic          lock_loss_flag,
   input  wire logic          vco_cal_active,
   input  wire logic [7:0]    irq_flag_bits,
   input  wire logic          eeprom_active,
   input  wire logic          switch_back_event,
   // Divider outputs, R N M order
   input  wire logic [N_DIV-1:0] div_level,
   input  wire logic [N_DIV-1:0] div_bypass,
   // Test override
   input  wire logic          test_claim,
   input  wire logic          test_level,
   // Pin
   output logic               second_status_pin
);

   ssp_apb_req_t req;
   ssp_cond_t    cond;
   ssp_div_t     divs;
   ssp_state_t   st_ff;
   ssp_state_t   nxt_st;
   logic [N_DIV-1:0] half_q;
   logic         interrupt_summary;
   logic         src_raw;
   logic         src_rsvd;
   logic         pin_level;
   logic         hit_ctrl;
   logic         hit_obs;
   logic [31:0]  rd_word;

   // Bundle the ports into carriers
   always_comb begin
      req.psel    = psel;
      req.penable = penable;
      req.pwrite  = pwrite;
      req.paddr   = paddr;
      req.pwdata  = pwdata;
      req.pstrb   = pstrb;
   end

   always_comb begin
      cond.pri_loss    = pri_signal_loss_flag;
      cond.sec_loss    = sec_signal_loss_flag;
      cond.lock_loss   = lock_loss_flag;
      cond.vco_cal     = vco_cal_active;
      cond.irq_flags   = irq_flag_bits;
      cond.eeprom_busy = eeprom_active;
      cond.switch_back = switch_back_event;
   end

   always_comb begin
      divs.level  = div_level[2:0];
      divs.bypass = div_bypass[2:0];
   end

   // One halving stage per divider
   genvar gi;
   generate
      for (gi = 0; gi < N_DIV; gi++) begin : g_half
         ssp_half_rate u_half (
            .clk        (clk),
            .rst        (rst),
            .div_level  (divs.level[gi]),
            .div_bypass (divs.bypass[gi]),
            .half_q     (half_q[gi])
         );
      end
   endgenerate

   // Any pending interrupt flag raises the summary
   assign interrupt_summary = |cond.irq_flags;

   // Source multiplexer, active high before polarity
   always_comb begin
      src_raw  = 1'b0;
      src_rsvd = 1'b0;
      case (st_ff.sel)
         `SSP_CODE_PRI_LOSS:    src_raw = cond.pri_loss;
         `SSP_CODE_SEC_LOSS:    src_raw = cond.sec_loss;
         `SSP_CODE_LOCK_LOSS:   src_raw = cond.lock_loss;
         `SSP_CODE_R_DIV2:      src_raw = half_q[0];
         `SSP_CODE_N_DIV2:      src_raw = half_q[1];
         `SSP_CODE_VCO_CAL:     src_raw = cond.vco_cal;
         `SSP_CODE_IRQ:         src_raw = interrupt_summary;
         `SSP_CODE_M_DIV2:      src_raw = half_q[2];
         `SSP_CODE_EEPROM:      src_raw = cond.eeprom_busy;
         `SSP_CODE_SWITCH_BACK: src_raw = cond.switch_back;
         default: begin
            // Reserved codes stay inactive rather than float
            src_raw  = 1'b0;
            src_rsvd = 1'b1;
         end
      endcase
   end

   // Polarity, then the test claim on top of everything
   always_comb begin
      if (test_claim) begin
         pin_level = test_level;
      end else if (st_ff.pol) begin
         pin_level = src_raw;
      end else begin
         pin_level = !src_raw;
      end
   end

   // Address decode and read word
   assign hit_ctrl = (req.paddr == `SSP_OFS_CTRL);
   assign hit_obs  = (req.paddr == `SSP_OFS_OBS);

   always_comb begin
      rd_word = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_word[`SSP_SEL_MSB:`SSP_SEL_LSB] = st_ff.sel;
         rd_word[`SSP_POL_BIT]              = st_ff.pol;
      end else if (hit_obs) begin
         rd_word[`SSP_OBS_PIN_BIT]  = st_ff.pin;
         rd_word[`SSP_OBS_RAW_BIT]  = st_ff.raw;
         rd_word[`SSP_OBS_TEST_BIT] = st_ff.test;
         rd_word[`SSP_OBS_RSVD_BIT] = src_rsvd;
      end
   end

   // Next state
   always_comb begin
      nxt_st      = st_ff;
      nxt_st.pin  = pin_level;
      nxt_st.raw  = src_raw;
      nxt_st.test = test_claim;
      // Answer is prepared in the setup cycle so pready is registered
      // and the access phase always lasts exactly one cycle
      if (req.psel && !req.penable) begin
         nxt_st.rsp.pready  = 1'b1;
         nxt_st.rsp.pslverr = !(hit_ctrl || hit_obs);
         nxt_st.rsp.prdata  = req.pwrite ? 32'h0000_0000 : rd_word;
      end else begin
         nxt_st.rsp.pready  = 1'b0;
         nxt_st.rsp.pslverr = 1'b0;
         nxt_st.rsp.prdata  = 32'h0000_0000;
      end
      // Write takes effect at the access edge; only the low lane matters
      if (req.psel && req.penable && st_ff.rsp.pready && req.pwrite &&
          hit_ctrl && req.pstrb[0]) begin
         nxt_st.sel = req.pwdata[`SSP_SEL_MSB:`SSP_SEL_LSB];
         nxt_st.pol = req.pwdata[`SSP_POL_BIT];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff      <= '0;
         st_ff.sel  <= `SSP_SEL_RST;
         st_ff.pol  <= `SSP_POL_RST;
         // Reset default shows lock loss inactive at active high polarity
         st_ff.pin  <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pready            = st_ff.rsp.pready;
   assign pslverr           = st_ff.rsp.pslverr;
   assign prdata            = st_ff.rsp.prdata;
   assign second_status_pin = st_ff.pin;

endmodule

`default_nettype wire

// ==== hw/ssp_defines.svh ====
// Purpose: Offsets, field positions, reset values and selector codes of the
//          status pin source select block.
// Assumes: Byte addresses on a 32-bit APB bus, one register per word.
// Notes:   Definitions only.
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

// Register byte offsets
`define SSP_OFS_CTRL          8'h1c
`define SSP_OFS_OBS           8'h20

// Control register fields
`define SSP_SEL_MSB           7
`define SSP_SEL_LSB           4
`define SSP_POL_BIT           3
`define SSP_SEL_RST           4'h2
`define SSP_POL_RST           1'h1

// Observation register fields
`define SSP_OBS_PIN_BIT       0
`define SSP_OBS_RAW_BIT       1
`define SSP_OBS_TEST_BIT      2
`define SSP_OBS_RSVD_BIT      3

// Selector codes
`define SSP_CODE_PRI_LOSS     4'h0
`define SSP_CODE_SEC_LOSS     4'h1
`define SSP_CODE_LOCK_LOSS    4'h2
`define SSP_CODE_R_DIV2       4'h3
`define SSP_CODE_N_DIV2       4'h4
`define SSP_CODE_VCO_CAL      4'h8
`define SSP_CODE_IRQ          4'ha
`define SSP_CODE_M_DIV2       4'hb
`define SSP_CODE_EEPROM       4'hd
`define SSP_CODE_SWITCH_BACK  4'he

`endif

// ==== hw/ssp_pkg.sv ====
// Purpose: Types shared by the status pin source select block.
// Assumes: Constants live in ssp_defines.svh.
// Notes:   Types only.
package ssp_pkg;

   // APB request as seen by the slave
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
      logic [3:0]  pstrb;
   } ssp_apb_req_t;

   // APB answer
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } ssp_apb_rsp_t;

   // Internal conditions that may be shown on the pin
   typedef struct packed {
      logic       pri_loss;
      logic       sec_loss;
      logic       lock_loss;
      logic       vco_cal;
      logic [7:0] irq_flags;
      logic       eeprom_busy;
      logic       switch_back;
   } ssp_cond_t;

   // Divider inputs: R, N and M in bits 0, 1 and 2
   typedef struct packed {
      logic [2:0] level;
      logic [2:0] bypass;
   } ssp_div_t;

   // State of the half rate divider
   typedef struct packed {
      logic prev;
      logic q;
   } ssp_half_t;

   // State of the top module
   typedef struct packed {
      logic [3:0]   sel;
      logic         pol;
      ssp_apb_rsp_t rsp;
      logic         pin;
      logic         raw;
      logic         test;
   } ssp_state_t;

endpackage

// ==== hw/ssp_half_rate.sv ====
// Purpose: Divides a divider output by two for display on the status pin.
// Assumes: div_level is synchronous to clk and slower than clk / 2.
// Notes:   Output is held low while the divider is bypassed.
`timescale 1ns/1ps
`default_nettype none

module ssp_half_rate
   import ssp_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Divider
   input  wire logic div_level,
   input  wire logic div_bypass,
   // Result
   output logic      half_q
);

   ssp_half_t st_ff;
   ssp_half_t nxt_st;

   always_comb begin
      nxt_st      = st_ff;
      nxt_st.prev = div_level;
      if (div_bypass) begin
         // Bypassed divider gives no meaningful edge to halve
         nxt_st.q = 1'b0;
      end else if (div_level && !st_ff.prev) begin
         nxt_st.q = !st_ff.q;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign half_q = st_ff.q;

endmodule

`default_nettype wire

// ==== tb/ssp_sel_sva.sv ====
// Purpose: Port checker of the status pin select block
// Assumes: Control byte is shadowed from APB writes
// Notes:   Pin checks wait four quiet edges to cover the pin pipeline
`timescale 1ns/1ps
`default_nettype none
module ssp_sel_sva
   import ssp_pkg::*;
#(parameter int N_DIV = 3)
(
   // APB
   input wire logic clk, rst, psel, penable, pwrite, pready, pslverr,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic [3:0] pstrb,
   // Sources, test and pin
   input wire logic pri_signal_loss_flag, sec_signal_loss_flag, lock_loss_flag, vco_cal_active,
   input wire logic eeprom_active, switch_back_event, test_claim, test_level, second_status_pin,
   input wire logic [7:0] irq_flag_bits,
   input wire logic [N_DIV-1:0] div_level, div_bypass
);
   logic [3:0] sel_ff;
   logic pol_ff;
   logic [1:0] dv;
   logic [15:0] lv;
   // Code 3 wraps to divider 0, code 4 to 1
   assign dv = (sel_ff == 4'hb) ? 2'h2 : sel_ff[1:0] + 2'h1;
   assign lv = {1'h0, switch_back_event, eeprom_active, 2'h0, |irq_flag_bits, 1'h0,
                vco_cal_active, 5'h0, lock_loss_flag, sec_signal_loss_flag, pri_signal_loss_flag};
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sel_ff <= 4'h2;
         pol_ff <= 1'h1;
      end else if (psel && penable && pready && pwrite && paddr == 8'h1c && pstrb[0]) begin
         sel_ff <= pwdata[7:4];
         pol_ff <= pwdata[3];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_calm;
      $stable({sel_ff, pol_ff, test_claim, test_level, lv, div_bypass})[*4];
   endsequence
   sequence s_done;
      psel && penable && pready;
   endsequence
   AST_RDY: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready timing wrong");
   AST_ERR: assert property (s_done |-> pslverr == (paddr != 8'h1c && paddr != 8'h20))
      else $error("pslverr wrong");
   AST_RD: assert property (
      s_done ##0 (!pwrite && paddr == 8'h1c) |-> prdata == {24'h0, sel_ff, pol_ff, 3'h0})
      else $error("control read wrong");
   AST_LVL: assert property (
      s_calm ##0 (!test_claim && sel_ff inside {0, 1, 2, 8, 10, 13, 14})
      |-> second_status_pin == (lv[sel_ff] ~^ pol_ff)) else $error("pin not the source");
   AST_RSV: assert property (
      s_calm ##0 (!test_claim && sel_ff inside {5, 6, 7, 9, 12, 15})
      |-> second_status_pin == !pol_ff) else $error("reserved code not inactive");
   AST_TST: assert property (
      s_calm ##0 test_claim |-> second_status_pin == test_level) else $error("test override lost");
   AST_BYP: assert property (
      s_calm ##0 (!test_claim && (sel_ff == 4'h3 && div_bypass[0] ||
                                  sel_ff == 4'hb && div_bypass[2]))
      |-> second_status_pin == !pol_ff) else $error("bypassed divider shown");
   AST_TOG: assert property (
      s_calm ##0 (!test_claim && sel_ff inside {3, 4, 11} && !div_bypass[dv] && $rose(div_level[dv]))
      |-> ##[1:4] $changed(second_status_pin)) else $error("halved divider not toggling");
endmodule
`default_nettype wire

// ==== tb/ssp_pin_obs.sv ====
// Purpose: Host logic that samples the second status pin
// Assumes: Pin is synchronous to clk
// Notes:   One flop, as a synchronous host would see the pin
`timescale 1ns/1ps
`default_nettype none
module ssp_pin_obs
   import ssp_pkg::*;
(
   // Clock, reset and pin
   input wire logic clk,
   input wire logic rst,
   input wire logic pin,
   // Sampled level
   output logic lvl
);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) lvl <= 1'h0;
      else lvl <= pin;
   end
endmodule
`default_nettype wire

// ==== tb/status_pin_source_select_test.sv ====
// Purpose: Self-checking bench of the status pin select block
// Assumes: 125 MHz clock; reset held for 12 cycles
// Notes:   Pin is judged through the host observer, so checks wait 7 edges
`timescale 1ns/1ps
`default_nettype none
module status_pin_source_select_test;
   import ssp_pkg::*;
   logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, test_claim = 1'h0;
   logic pri_signal_loss_flag = 1'h0, sec_signal_loss_flag = 1'h0, lock_loss_flag = 1'h0;
   logic vco_cal_active = 1'h0, eeprom_active = 1'h0, switch_back_event = 1'h0, test_level = 1'h0;
   logic pready, pslverr, second_status_pin, seen, err;
   logic [7:0] paddr = 8'h00, irq_flag_bits = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, r, seed = 32'hcf61;
   logic [3:0] pstrb = 4'hf;
   logic [2:0] div_level = 3'h0, div_bypass = 3'h0;
   int miscompares = 0, cmp_count = 0, sel_m = 2, pol_m = 1, rises[3] = '{0, 0, 0};
   always #4 clk = ~clk;
   ssp_status_pin_select #(.N_DIV(3)) u_dut (.*);
   ssp_pin_obs u_obs (.clk(clk), .rst(rst), .pin(second_status_pin), .lvl(seen));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Expected pin; halved dividers follow the parity of counted rises
   function automatic logic pin_m();
      logic [2:0] h;
      logic [15:0] v;
      h = ~div_bypass & {rises[2][0], rises[1][0], rises[0][0]};
      v = {1'h0, switch_back_event, eeprom_active, 1'h0, h[2], |irq_flag_bits, 1'h0, vco_cal_active,
           3'h0, h[1], h[0], lock_loss_flag, sec_signal_loss_flag, pri_signal_loss_flag};
      return test_claim ? test_level : v[sel_m] ~^ pol_m[0];
   endfunction
   task automatic wt(int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      chk("pready", 32'h1, {31'h0, pready});
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wctl(int s, int p);
      apb(1'h1, 8'h1c, {24'h0, s[3:0], p[0], 3'h7});
      sel_m = s;
      pol_m = p;
   endtask
   task automatic pchk();
      wt(7);
      chk("pin", {31'h0, pin_m()}, {31'h0, seen});
   endtask
   task automatic rctl();
      apb(1'h0, 8'h1c, 32'h0);
      chk("ctrl", {24'h0, sel_m[3:0], pol_m[0], 3'h0}, rd);
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      wt(12);
      rst <= 1'h0;
      lock_loss_flag <= 1'h1;
      rctl();
      pchk();
      $display("reset values done");
      for (int i = 0; i < 32; i++) begin
         r = rnd();
         {pri_signal_loss_flag, sec_signal_loss_flag, lock_loss_flag, vco_cal_active,
          eeprom_active, switch_back_event, irq_flag_bits} <= r[13:0];
         wctl(i % 16, r[20]);
         pchk();
         rctl();
         apb(1'h0, 8'h20, 32'h0);
         chk("obs", {28'h0, (sel_m inside {5, 6, 7, 9, 12, 15}), 1'h0,
                     pin_m() ~^ pol_m[0], pin_m()}, rd);
      end
      $display("source sweep done");
      for (int j = 0; j < 3; j++) begin
         wctl(j == 2 ? 11 : 3 + j, j % 2);
         repeat (4) begin
            if (!div_level[j]) rises[j]++;
            div_level[j] <= !div_level[j];
            pchk();
         end
      end
      test_claim <= 1'h1;
      for (int k = 0; k < 4; k++) begin
         test_level <= k[0];
         wctl(k, k / 2);
         pchk();
      end
      test_claim <= 1'h0;
      div_bypass <= 3'h5;
      wctl(3, 1);
      pchk();
      wctl(11, 0);
      pchk();
      $display("divider and override done");
      apb(1'h0, 8'h44, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      chk("rdata", 32'h0, rd);
      apb(1'h1, 8'h20, 32'hf0);
      pstrb <= 4'he;
      apb(1'h1, 8'h1c, 32'h50);
      pstrb <= 4'hf;
      rctl();
      rst <= 1'h1;
      wt(2);
      rst <= 1'h0;
      sel_m = 2;
      pol_m = 1;
      rctl();
      $display("refusal and reset done");
      tally_and_finish();
   end
   initial begin
      wt(5000);
      miscompares++;
      tally_and_finish();
   end
endmodule
bind ssp_status_pin_select ssp_sel_sva #(.N_DIV(N_DIV)) u_sva (.*);
`default_nettype wire
